// ---- rtl/address_table_lookup_control.sv ----
// address table lookup control: APB registers, flush sequencing, aging, filtering
// assumes an APB master on SYS_CLK_I and a lookup table that acknowledges flushes
//
// Operation
// - bit 7 set stops unicast learning
// - drop frames whose source equals own MAC
// - self filter needs port and global enable
// - bit 5 starts table flush, self-clears
// - table flush reaches static table with scope 10 or 11
// - both flushes obey the flush scope
// - bit 4 flushes matching spanning-tree entries
// - bit 3 clear drops multicast sources
// - bit 2 clear stops all aging
// - bit 1 selects fast aging rate
// - bit 0 flushes ports whose link drops
// - scope 01 dyn, 10 static, 11 both
// - age count loaded on dynamic updates
`timescale 1ns/1ps
module address_table_lookup_control #(
   parameter int unsigned AGE_UNIT_CYC = atl_pkg::AGE_UNIT_CYC
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // neighbouring settings
   input wire logic [47:0] SELF_MAC_I,
   input wire logic [atl_pkg::NUM_PORTS-1:0] PORT_FILT_EN_I,
   // received frames
   input wire logic RX_VALID_I,
   input wire logic [2:0] RX_PORT_I,
   input wire logic [47:0] RX_SA_I,
   output logic RX_DONE_O,
   output logic RX_DROP_O,
   output logic RX_LEARN_O,
   output logic [2:0] AGE_COUNT_O,
   // aging
   output logic AGE_TICK_O,
   // link state
   input wire logic [atl_pkg::NUM_PORTS-1:0] LINK_UP_I,
   // flush command to the lookup table
   output logic FLUSH_VALID_O,
   output atl_pkg::flush_kind_type FLUSH_KIND_O,
   output atl_pkg::flush_scope_type FLUSH_SCOPE_O,
   output logic [2:0] FLUSH_PORT_O,
   input wire logic FLUSH_DONE_I
);
   import atl_pkg::*;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [11:0] addr, input logic [11:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction

   logic [7:0] ctrl0_q;
   logic [7:0] ctrl1_q;
   logic [7:0] ctrl2_q;
   logic [7:0] age_period_q;

   logic setup;
   logic wr_en;
   logic mapped;

   logic [7:0] rd_val;
   logic [7:0] status;

   flush_state_type fl_state_q;
   flush_kind_type fl_kind_q;
   logic [2:0] fl_port_q;

   logic fl_done;
   logic done_all;
   logic done_mstp;
   logic [NUM_PORTS-1:0] done_port;

   logic [NUM_PORTS-1:0] link_q;
   logic [NUM_PORTS-1:0] ld_pend_q;
   logic any_pend;
   logic [2:0] pend_idx;

   flush_scope_type scope;

   // setup taken only while idle
   assign setup = PSEL_I && !PENABLE_I && !PREADY_O;
   // write lands with pready
   assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
   assign scope = flush_scope_type'(ctrl2_q[C2_SCOPE_LO +: 2]);

   // register read decode
   always_comb begin
      mapped = hit(PADDR_I, ADDR_CTRL0) || hit(PADDR_I, ADDR_CTRL1) ||
               hit(PADDR_I, ADDR_CTRL2) || hit(PADDR_I, ADDR_AGE_PERIOD) ||
               hit(PADDR_I, ADDR_STATUS);
      // busy flag and pendings
      status = {(fl_state_q == FL_WAIT), ld_pend_q};
      rd_val = 8'h00;
      if (hit(PADDR_I, ADDR_CTRL0)) begin
         rd_val = ctrl0_q;
      end else if (hit(PADDR_I, ADDR_CTRL1)) begin
         rd_val = ctrl1_q;
      end else if (hit(PADDR_I, ADDR_CTRL2)) begin
         rd_val = ctrl2_q;
      end else if (hit(PADDR_I, ADDR_AGE_PERIOD)) begin
         rd_val = age_period_q;
      end else if (hit(PADDR_I, ADDR_STATUS)) begin
         rd_val = status;
      end
   end

   // ---------------------------------------------------------------
   // apb handshake and read data
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h00000000;
      end else begin
         // one ready pulse, no wait
         PREADY_O <= setup;
         if (setup) begin
            PSLVERR_O <= !mapped;
            // held for the access cycle
            PRDATA_O <= (!PWRITE_I) ? {24'h000000, rd_val} : 32'h00000000;
         end else begin
            PSLVERR_O <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // plain configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ctrl0_q <= CTRL0_RST;
         ctrl2_q <= CTRL2_RST;
         age_period_q <= AGE_PERIOD_RST;
      end else if (wr_en) begin
         if (hit(PADDR_I, ADDR_CTRL0)) begin
            ctrl0_q <= PWDATA_I[7:0];
         end

         if (hit(PADDR_I, ADDR_CTRL2)) begin
            ctrl2_q <= PWDATA_I[7:0];
         end

         if (hit(PADDR_I, ADDR_AGE_PERIOD)) begin
            age_period_q <= PWDATA_I[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // lookup control register with self-clearing flush bits
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ctrl1_q <= CTRL1_RST;
      end else begin
         // plain bits
         if (wr_en && hit(PADDR_I, ADDR_CTRL1)) begin
            ctrl1_q[7:6] <= PWDATA_I[7:6];
            ctrl1_q[3:0] <= PWDATA_I[3:0];
         end

         ctrl1_q[C1_FLUSH_ALL] <= (wr_en && hit(PADDR_I, ADDR_CTRL1) &&
                                   PWDATA_I[C1_FLUSH_ALL]) ||
                                  (ctrl1_q[C1_FLUSH_ALL] && !done_all);

         ctrl1_q[C1_FLUSH_MSTP] <= (wr_en && hit(PADDR_I, ADDR_CTRL1) &&
                                    PWDATA_I[C1_FLUSH_MSTP]) ||
                                   (ctrl1_q[C1_FLUSH_MSTP] && !done_mstp);
      end
   end

   // ---------------------------------------------------------------
   // link-down tracking
   // ---------------------------------------------------------------
   // previous link level
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         link_q <= '0;
      end else begin
         link_q <= LINK_UP_I;
      end
   end

   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         // ends with its own flush
         assign done_port[gp] = fl_done && (fl_kind_q == KIND_PORT) &&
                                (fl_port_q == 3'(gp));
         always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
               ld_pend_q[gp] <= 1'b0;
            end else begin
               // set wins over done
               // link-down flush request
               ld_pend_q[gp] <= (ctrl1_q[C1_LINK_FLUSH] && link_q[gp] && !LINK_UP_I[gp]) ||
                                (ld_pend_q[gp] && !done_port[gp]);
            end
         end
      end
   endgenerate

   // lowest port served first
   always_comb begin
      any_pend = |ld_pend_q;
      pend_idx = 3'h0;
      for (int i = NUM_PORTS - 1; i >= 0; i--) begin
         if (ld_pend_q[i]) begin
            pend_idx = 3'(i);
         end
      end
   end

   // ---------------------------------------------------------------
   // flush sequencer
   // ---------------------------------------------------------------
   // answer counts only when out
   assign fl_done = (fl_state_q == FL_WAIT) && FLUSH_DONE_I;
   assign done_all = (fl_done && fl_kind_q == KIND_ALL) ||
                     (fl_state_q == FL_IDLE && ctrl1_q[C1_FLUSH_ALL] && scope == SCOPE_NONE);

   assign done_mstp = (fl_done && fl_kind_q == KIND_MSTP) ||
                      (fl_state_q == FL_IDLE && !ctrl1_q[C1_FLUSH_ALL] &&
                       ctrl1_q[C1_FLUSH_MSTP] && scope == SCOPE_NONE);

   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         fl_state_q <= FL_IDLE;
         fl_kind_q <= KIND_ALL;
         fl_port_q <= 3'h0;

         FLUSH_VALID_O <= 1'b0;
         FLUSH_KIND_O <= KIND_ALL;
         FLUSH_SCOPE_O <= SCOPE_NONE;
         FLUSH_PORT_O <= 3'h0;
      end else begin
         unique case (fl_state_q)
            FL_IDLE: begin
               if (ctrl1_q[C1_FLUSH_ALL] && scope != SCOPE_NONE) begin
                  fl_state_q <= FL_WAIT;
                  fl_kind_q <= KIND_ALL;
                  FLUSH_VALID_O <= 1'b1;
                  FLUSH_KIND_O <= KIND_ALL;
                  FLUSH_SCOPE_O <= scope;
               end else if (!ctrl1_q[C1_FLUSH_ALL] && ctrl1_q[C1_FLUSH_MSTP] &&
                            scope != SCOPE_NONE) begin
                  fl_state_q <= FL_WAIT;
                  fl_kind_q <= KIND_MSTP;
                  FLUSH_VALID_O <= 1'b1;
                  FLUSH_KIND_O <= KIND_MSTP;
                  FLUSH_SCOPE_O <= scope;
               end else if (!ctrl1_q[C1_FLUSH_ALL] && !ctrl1_q[C1_FLUSH_MSTP] && any_pend) begin
                  fl_state_q <= FL_WAIT;
                  fl_kind_q <= KIND_PORT;
                  fl_port_q <= pend_idx;
                  FLUSH_VALID_O <= 1'b1;
                  FLUSH_KIND_O <= KIND_PORT;
                  FLUSH_SCOPE_O <= SCOPE_DYN;
                  FLUSH_PORT_O <= pend_idx;
               end
            end

            FL_WAIT: begin
               // held until done
               if (FLUSH_DONE_I) begin
                  fl_state_q <= FL_IDLE;
                  FLUSH_VALID_O <= 1'b0;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // age count for dynamic entry updates
   // ---------------------------------------------------------------
   // one cycle behind the register
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         AGE_COUNT_O <= CTRL0_RST[C0_AGE_CNT_LO +: 3];
      end else begin
         AGE_COUNT_O <= ctrl0_q[C0_AGE_CNT_LO +: 3];
      end
   end

   // ---------------------------------------------------------------
   // frame checks and aging timer
   // ---------------------------------------------------------------
   // verdicts one cycle later
   atl_frame_filter u_filter (
      .clk_i(SYS_CLK_I),
      .rst_b_i(RST_B_I),
      .rx_valid_i(RX_VALID_I),
      .rx_port_i(RX_PORT_I),
      .rx_sa_i(RX_SA_I),
      .self_mac_i(SELF_MAC_I),
      .port_filt_en_i(PORT_FILT_EN_I),
      .self_filt_i(ctrl1_q[C1_SELF_FILT]),
      .mcast_fwd_i(ctrl1_q[C1_MCAST_FWD]),
      .learn_dis_i(ctrl1_q[C1_LEARN_DIS]),
      .done_o(RX_DONE_O),
      .drop_o(RX_DROP_O),
      .learn_o(RX_LEARN_O)
   );

   // aging ticks
   atl_age_timer #(
      .UNIT_CYC(AGE_UNIT_CYC)
   ) u_age (
      .clk_i(SYS_CLK_I),
      .rst_b_i(RST_B_I),
      .age_en_i(ctrl1_q[C1_AGE_EN]),
      .fast_i(ctrl1_q[C1_FAST_AGE]),
      .period_i(age_period_q),
      .tick_o(AGE_TICK_O)
   );

endmodule

// ---- rtl/atl_pkg.sv ----
// constants, field positions and types of the address table lookup control
// assumes a 10 MHz core clock and a 32-bit APB register port
package atl_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned AGE_UNIT_US = 1000;
   localparam int unsigned AGE_UNIT_CYC = AGE_UNIT_US * (CLK_HZ / 1_000_000);

   // ---------------------------------------------------------------
   // register indices and byte addresses
   // ---------------------------------------------------------------
   localparam logic [9:0] IDX_CTRL0 = 10'h310;
   localparam logic [9:0] IDX_CTRL1 = 10'h311;
   localparam logic [9:0] IDX_CTRL2 = 10'h312;
   localparam logic [9:0] IDX_AGE_PERIOD = 10'h313;
   localparam logic [9:0] IDX_STATUS = 10'h314;
   localparam logic [11:0] ADDR_CTRL0 = {IDX_CTRL0, 2'b00};
   localparam logic [11:0] ADDR_CTRL1 = {IDX_CTRL1, 2'b00};
   localparam logic [11:0] ADDR_CTRL2 = {IDX_CTRL2, 2'b00};
   localparam logic [11:0] ADDR_AGE_PERIOD = {IDX_AGE_PERIOD, 2'b00};
   localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int C1_LEARN_DIS = 7;
   localparam int C1_SELF_FILT = 6;
   localparam int C1_FLUSH_ALL = 5;
   localparam int C1_FLUSH_MSTP = 4;
   localparam int C1_MCAST_FWD = 3;
   localparam int C1_AGE_EN = 2;
   localparam int C1_FAST_AGE = 1;
   localparam int C1_LINK_FLUSH = 0;
   localparam int C0_AGE_CNT_LO = 3;
   localparam int C2_SCOPE_LO = 2;
   localparam int SA_GROUP_BIT = 40;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL0_RST = 8'h61;
   localparam logic [7:0] CTRL1_RST = 8'h0C;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] AGE_PERIOD_RST = 8'h4B;

   localparam int NUM_PORTS = 7;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SCOPE_NONE = 2'b00,
      SCOPE_DYN = 2'b01,
      SCOPE_STAT = 2'b10,
      SCOPE_BOTH = 2'b11
   } flush_scope_type;

   typedef enum logic [1:0] {
      KIND_ALL = 2'b00,
      KIND_MSTP = 2'b01,
      KIND_PORT = 2'b10
   } flush_kind_type;

   typedef enum logic [0:0] {
      FL_IDLE = 1'b0,
      FL_WAIT = 1'b1
   } flush_state_type;

endpackage

// ---- rtl/atl_frame_filter.sv ----
// per-frame source address checks: self filter, multicast drop, learning
// assumes one frame offered per valid pulse, inputs synchronous to clk_i
`timescale 1ns/1ps
module atl_frame_filter (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // frame
   input wire logic rx_valid_i,
   input wire logic [2:0] rx_port_i,
   input wire logic [47:0] rx_sa_i,
   // settings
   input wire logic [47:0] self_mac_i,
   input wire logic [atl_pkg::NUM_PORTS-1:0] port_filt_en_i,
   input wire logic self_filt_i,
   input wire logic mcast_fwd_i,
   input wire logic learn_dis_i,
   // verdict
   output logic done_o,
   output logic drop_o,
   output logic learn_o
);
   import atl_pkg::*;

   logic port_en;
   logic self_hit;
   logic mcast_sa;
   logic drop_d;

   always_comb begin
      port_en = (rx_port_i < 3'(NUM_PORTS)) ? port_filt_en_i[rx_port_i] : 1'b0;
      self_hit = self_filt_i && port_en && (rx_sa_i == self_mac_i);
      mcast_sa = rx_sa_i[SA_GROUP_BIT];
      drop_d = self_hit || (!mcast_fwd_i && mcast_sa);
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_o <= 1'b0;
         drop_o <= 1'b0;
         learn_o <= 1'b0;
      end else begin
         done_o <= rx_valid_i;
         drop_o <= rx_valid_i && drop_d;
         learn_o <= rx_valid_i && !drop_d && !mcast_sa && !learn_dis_i;
      end
   end

endmodule

// ---- rtl/atl_age_timer.sv ----
// aging tick generator: normal rate from the age period, fast rate per unit
// assumes UNIT_CYC is a fixed, non-zero count of core clocks
`timescale 1ns/1ps
module atl_age_timer #(
   parameter int unsigned UNIT_CYC = atl_pkg::AGE_UNIT_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // settings
   input wire logic age_en_i,
   input wire logic fast_i,
   input wire logic [7:0] period_i,
   // tick
   output logic tick_o
);
   import atl_pkg::*;

   logic [23:0] unit_cnt_q;
   logic [7:0] period_cnt_q;
   logic unit_end;

   assign unit_end = (unit_cnt_q == 24'(UNIT_CYC - 1));

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         unit_cnt_q <= 24'h000000;
      end else if (!age_en_i || unit_end) begin
         unit_cnt_q <= 24'h000000;
      end else begin
         unit_cnt_q <= unit_cnt_q + 24'h000001;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         period_cnt_q <= 8'h00;
         tick_o <= 1'b0;
      end else if (!age_en_i) begin
         period_cnt_q <= 8'h00;
         tick_o <= 1'b0;
      end else if (unit_end) begin
         if (fast_i || (period_cnt_q + 8'h01 >= period_i)) begin
            period_cnt_q <= 8'h00;
            tick_o <= 1'b1;
         end else begin
            period_cnt_q <= period_cnt_q + 8'h01;
            tick_o <= 1'b0;
         end
      end else begin
         tick_o <= 1'b0;
      end
   end

endmodule

// ---- dv/address_table_lookup_control_properties.sv ----
// port checker of the address table lookup control
// assumes one clock domain and binding onto the top module
`timescale 1ns/1ps
module atl_ctrl_checker #(
   parameter int unsigned AGE_UNIT_CYC = 4
) (
   // clock, reset, apb
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PREADY_O,
   // frames
   input wire logic RX_VALID_I,
   input wire logic [2:0] RX_PORT_I,
   input wire logic [47:0] RX_SA_I,
   input wire logic [47:0] SELF_MAC_I,
   input wire logic [atl_pkg::NUM_PORTS-1:0] PORT_FILT_EN_I,
   input wire logic RX_DONE_O,
   input wire logic RX_DROP_O,
   input wire logic RX_LEARN_O,
   // aging and flush
   input wire logic AGE_TICK_O,
   input wire logic FLUSH_VALID_O,
   input atl_pkg::flush_kind_type FLUSH_KIND_O,
   input atl_pkg::flush_scope_type FLUSH_SCOPE_O,
   input wire logic [2:0] FLUSH_PORT_O,
   input wire logic FLUSH_DONE_I
);
   import atl_pkg::*;
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_B_I);
   // ----------------
   // tick spacing
   // ----------------
   logic [15:0] gap_q;
   always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         gap_q <= 16'hFFFF;
      end else if (AGE_TICK_O) begin
         gap_q <= 16'h0000;
      end else if (gap_q != 16'hFFFF) begin
         gap_q <= gap_q + 16'h0001;
      end
   end
   property p_tick_gap;
      AGE_TICK_O |-> gap_q >= 16'(AGE_UNIT_CYC - 1);
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("age ticks too close");
   property p_rx_done;
      RX_VALID_I |=> RX_DONE_O;
   endproperty
   a_rx_done: assert property (p_rx_done) else $error("frame verdict missing");
   property p_rx_quiet;
      !RX_VALID_I |=> !RX_DONE_O && !RX_DROP_O && !RX_LEARN_O;
   endproperty
   a_rx_quiet: assert property (p_rx_quiet) else $error("verdict without frame");
   property p_mcast_nolearn;
      RX_VALID_I && RX_SA_I[SA_GROUP_BIT] |=> !RX_LEARN_O;
   endproperty
   a_mcast_nolearn: assert property (p_mcast_nolearn) else $error("group source learned");
   property p_no_self;
      RX_VALID_I && !RX_SA_I[SA_GROUP_BIT] && (RX_SA_I != SELF_MAC_I || RX_PORT_I >= 3'h7
         || !PORT_FILT_EN_I[RX_PORT_I]) |=> !RX_DROP_O;
   endproperty
   a_no_self: assert property (p_no_self) else $error("unicast frame dropped");
   property p_learn_drop;
      RX_DROP_O |-> RX_DONE_O && !RX_LEARN_O;
   endproperty
   a_learn_drop: assert property (p_learn_drop) else $error("dropped frame learned");
   property p_flush_hold;
      FLUSH_VALID_O && !FLUSH_DONE_I |=> FLUSH_VALID_O && $stable(FLUSH_KIND_O)
         && $stable(FLUSH_SCOPE_O) && $stable(FLUSH_PORT_O);
   endproperty
   a_flush_hold: assert property (p_flush_hold) else $error("flush command changed");
   property p_flush_end;
      FLUSH_VALID_O && FLUSH_DONE_I |=> !FLUSH_VALID_O;
   endproperty
   a_flush_end: assert property (p_flush_end) else $error("flush outlived done");
   property p_scope_nz;
      FLUSH_VALID_O |-> FLUSH_SCOPE_O != SCOPE_NONE;
   endproperty
   a_scope_nz: assert property (p_scope_nz) else $error("flush with empty scope");
   property p_port_dyn;
      FLUSH_VALID_O && FLUSH_KIND_O == KIND_PORT |-> FLUSH_SCOPE_O == SCOPE_DYN;
   endproperty
   a_port_dyn: assert property (p_port_dyn) else $error("port flush not dynamic");
   property p_apb_ready;
      PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");
endmodule

bind address_table_lookup_control atl_ctrl_checker #(.AGE_UNIT_CYC(AGE_UNIT_CYC)) i_chk (
   .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PREADY_O(PREADY_O), .RX_VALID_I(RX_VALID_I), .RX_PORT_I(RX_PORT_I), .RX_SA_I(RX_SA_I),
   .SELF_MAC_I(SELF_MAC_I), .PORT_FILT_EN_I(PORT_FILT_EN_I), .RX_DONE_O(RX_DONE_O),
   .RX_DROP_O(RX_DROP_O), .RX_LEARN_O(RX_LEARN_O), .AGE_TICK_O(AGE_TICK_O),
   .FLUSH_VALID_O(FLUSH_VALID_O), .FLUSH_KIND_O(FLUSH_KIND_O), .FLUSH_SCOPE_O(FLUSH_SCOPE_O),
   .FLUSH_PORT_O(FLUSH_PORT_O), .FLUSH_DONE_I(FLUSH_DONE_I));

// ---- dv/address_table_lookup_control_tb.sv ----
// self-checking bench of the address table lookup control
// assumes the bound port checker and a short aging unit
`timescale 1ns/1ps
module address_table_lookup_control_tb;
   import atl_pkg::*;
   localparam int unsigned UNIT = 4;
   localparam logic [47:0] MAC = 48'h0211_2233_4455;
   localparam logic [47:0] MCAST = 48'h0100_5E00_0001;
   localparam logic [47:0] OTHER = 48'h0211_2233_4466;
   logic SYS_CLK_I, RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O;
   logic [11:0] PADDR_I;
   logic [31:0] PWDATA_I, PRDATA_O;
   logic [47:0] SELF_MAC_I, RX_SA_I;
   logic [6:0] PORT_FILT_EN_I, LINK_UP_I;
   logic RX_VALID_I, RX_DONE_O, RX_DROP_O, RX_LEARN_O, AGE_TICK_O, FLUSH_VALID_O, FLUSH_DONE_I;
   logic [2:0] RX_PORT_I, AGE_COUNT_O, FLUSH_PORT_O;
   flush_kind_type FLUSH_KIND_O;
   flush_scope_type FLUSH_SCOPE_O;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   address_table_lookup_control #(.AGE_UNIT_CYC(UNIT)) i_dut (
      .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
      .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
      .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SELF_MAC_I(SELF_MAC_I),
      .PORT_FILT_EN_I(PORT_FILT_EN_I), .RX_VALID_I(RX_VALID_I), .RX_PORT_I(RX_PORT_I),
      .RX_SA_I(RX_SA_I), .RX_DONE_O(RX_DONE_O), .RX_DROP_O(RX_DROP_O),
      .RX_LEARN_O(RX_LEARN_O), .AGE_COUNT_O(AGE_COUNT_O), .AGE_TICK_O(AGE_TICK_O),
      .LINK_UP_I(LINK_UP_I), .FLUSH_VALID_O(FLUSH_VALID_O), .FLUSH_KIND_O(FLUSH_KIND_O),
      .FLUSH_SCOPE_O(FLUSH_SCOPE_O), .FLUSH_PORT_O(FLUSH_PORT_O), .FLUSH_DONE_I(FLUSH_DONE_I));
   // ----------------
   // common tasks
   // ----------------
   task automatic print_verdict();
      if (fail_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
      output logic [31:0] rd, output logic err);
      @(posedge SYS_CLK_I);
      PSEL_I <= 1'b1;
      PWRITE_I <= wr;
      PADDR_I <= a;
      PWDATA_I <= {24'h000000, d};
      @(posedge SYS_CLK_I);
      PENABLE_I <= 1'b1;
      do begin
         @(posedge SYS_CLK_I);
      end while (PREADY_O !== 1'b1);
      rd = PRDATA_O;
      err = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
      input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 8'h00, rd, err);
      chk(what, exp, rd);
      chk(what, {31'h0, exp_err}, {31'h0, err});
   endtask
   task automatic frame(input logic [2:0] p, input logic [47:0] sa, input logic drop,
      input logic learn);
      @(posedge SYS_CLK_I);
      RX_VALID_I <= 1'b1;
      RX_PORT_I <= p;
      RX_SA_I <= sa;
      @(posedge SYS_CLK_I);
      RX_VALID_I <= 1'b0;
      @(negedge SYS_CLK_I);
      chk("verdict", {29'h0, 1'b1, drop, learn}, {29'h0, RX_DONE_O, RX_DROP_O, RX_LEARN_O});
   endtask
   task automatic done_pulse();
      @(posedge SYS_CLK_I);
      FLUSH_DONE_I <= 1'b1;
      @(posedge SYS_CLK_I);
      FLUSH_DONE_I <= 1'b0;
      @(negedge SYS_CLK_I);
      chk("flush end", 32'h0, {31'h0, FLUSH_VALID_O});
   endtask
   task automatic ticks(input string what, input int exp);
      int n;
      n = 0;
      repeat (16) @(posedge SYS_CLK_I);
      repeat (10 * UNIT) begin
         @(negedge SYS_CLK_I);
         if (AGE_TICK_O === 1'b1) n++;
      end
      chk(what, exp, n);
   endtask
   // ----------------
   // scenarios
   // ----------------
   task automatic t_reset();
      rd_chk("ctrl1", ADDR_CTRL1, 32'h0000000C, 1'b0);
      rd_chk("ctrl0", ADDR_CTRL0, 32'h00000061, 1'b0);
      rd_chk("unmapped", 12'hC60, 32'h00000000, 1'b1);
      chk("age count", 32'h4, {29'h0, AGE_COUNT_O});
      wr(ADDR_CTRL0, 8'h28);
      @(posedge SYS_CLK_I);
      @(negedge SYS_CLK_I);
      chk("age count", 32'h5, {29'h0, AGE_COUNT_O});
   endtask
   task automatic t_frames();
      frame(3'h0, MAC, 1'b0, 1'b1);
      frame(3'h0, MCAST, 1'b0, 1'b0);
      wr(ADDR_CTRL1, 8'h44);
      frame(3'h0, MAC, 1'b1, 1'b0);
      frame(3'h1, MAC, 1'b0, 1'b1);
      frame(3'h1, MCAST, 1'b1, 1'b0);
      wr(ADDR_CTRL1, 8'hCC);
      frame(3'h3, OTHER, 1'b0, 1'b0);
      wr(ADDR_CTRL1, 8'h0C);
      frame(3'h3, OTHER, 1'b0, 1'b1);
   endtask
   task automatic flush(input logic [7:0] c1, input logic [7:0] c2, input logic [1:0] kind);
      wr(ADDR_CTRL2, c2);
      wr(ADDR_CTRL1, c1);
      @(posedge SYS_CLK_I);
      @(negedge SYS_CLK_I);
      chk("flush cmd", {27'h0, 1'b1, kind, c2[3:2]},
         {27'h0, FLUSH_VALID_O, FLUSH_KIND_O, FLUSH_SCOPE_O});
      rd_chk("busy", ADDR_CTRL1, {24'h0, c1}, 1'b0);
      done_pulse();
      rd_chk("self clear", ADDR_CTRL1, {24'h0, c1 & 8'hCF}, 1'b0);
   endtask
   task automatic t_link();
      int n;
      n = 0;
      wr(ADDR_CTRL1, 8'h0D);
      @(posedge SYS_CLK_I);
      LINK_UP_I[2] <= 1'b0;
      do begin
         @(negedge SYS_CLK_I);
         n++;
      end while (FLUSH_VALID_O !== 1'b1 && n < 10);
      chk("port flush", {24'h0, 1'b1, KIND_PORT, SCOPE_DYN, 3'h2},
         {24'h0, FLUSH_VALID_O, FLUSH_KIND_O, FLUSH_SCOPE_O, FLUSH_PORT_O});
      done_pulse();
      rd_chk("pending", ADDR_STATUS, 32'h0, 1'b0);
      wr(ADDR_CTRL1, 8'h0C);
      @(posedge SYS_CLK_I);
      LINK_UP_I[3] <= 1'b0;
      repeat (10) @(negedge SYS_CLK_I);
      chk("no port flush", 32'h0, {31'h0, FLUSH_VALID_O});
   endtask
   initial begin
      SYS_CLK_I = 1'b0;
      forever #50 SYS_CLK_I = ~SYS_CLK_I;
   end
   always @(posedge SYS_CLK_I) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      {RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, RX_VALID_I, FLUSH_DONE_I} = 6'h00;
      PADDR_I = 12'h000;
      PWDATA_I = 32'h0;
      RX_PORT_I = 3'h0;
      RX_SA_I = 48'h0;
      SELF_MAC_I = MAC;
      PORT_FILT_EN_I = 7'h05;
      LINK_UP_I = 7'h7F;
      repeat (6) @(posedge SYS_CLK_I);
      RST_B_I <= 1'b1;
      t_reset();
      t_frames();
      flush(8'h2C, 8'h04, KIND_ALL);
      flush(8'h1C, 8'h0C, KIND_MSTP);
      flush(8'h2C, 8'h08, KIND_ALL);
      wr(ADDR_CTRL2, 8'h00);
      wr(ADDR_CTRL1, 8'h2C);
      rd_chk("no scope", ADDR_CTRL1, 32'h0C, 1'b0);
      t_link();
      wr(ADDR_CTRL1, 8'h0E);
      ticks("fast", 10);
      wr(ADDR_AGE_PERIOD, 8'h02);
      wr(ADDR_CTRL1, 8'h0C);
      ticks("normal", 5);
      wr(ADDR_CTRL1, 8'h08);
      ticks("off", 0);
      print_verdict();
   end
endmodule
